// ### inc/spb_pkg.sv
// constants and types shared by the separate-port burst memory files
package spb_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 19;
  localparam int WORD_W      = 18;
  localparam int BURST       = 4;
  localparam int LINE_W      = 72;
  localparam int BYTE_W      = 9;
  localparam int MASK_W      = 8;
  localparam int MEM_DEPTH   = 524288;
  localparam int BYTE_LO_LSB = 0;
  localparam int BYTE_HI_LSB = 9;
  localparam int CMD_W       = ADDR_W + LINE_W + MASK_W;
  localparam int PIN_W       = 2 + ADDR_W + WORD_W + 2 + 1;

  // ----------------------------------------------------------------
  // timing, in clk edges (one clk edge per input clock rise)
  // ----------------------------------------------------------------
  localparam int RD_LAT_PLL    = 5;
  localparam int RD_LAT_LEGACY = 2;
  localparam int RD_DLY_DEPTH  = RD_LAT_PLL - 1;
  localparam int WR_DATA_DLY   = 2;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic PHASE_K     = 1'b0;
  localparam logic PHASE_RST   = PHASE_K;
  localparam logic PIN_RST_BIT = 1'b1;
  localparam logic OE_RST      = 1'b0;

  typedef logic [ADDR_W-1:0] spb_addr_t;
  typedef logic [WORD_W-1:0] spb_word_t;
  typedef logic [LINE_W-1:0] spb_line_t;

  typedef enum logic [1:0] {
    SPB_WR_IDLE    = 2'b01,
    SPB_WR_COLLECT = 2'b10
  } spb_wr_state_e;

endpackage

// ### inc/spb_stream_if.sv
// valid/ready word channel used between the memory block's own modules
`timescale 1ns/1ps
interface spb_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### hw/spb_mem_bank.sv
// one 512K x 18 storage array with per-byte write enables
`timescale 1ns/1ps
module spb_mem_bank (
  input  wire logic                      clk,
  input  wire logic                      we,
  input  wire logic [1:0]                wmask,
  input  wire logic [spb_pkg::ADDR_W-1:0] waddr,
  input  wire logic [spb_pkg::WORD_W-1:0] wdata,
  input  wire logic [spb_pkg::ADDR_W-1:0] raddr,
  output logic      [spb_pkg::WORD_W-1:0] rdata
);

  logic [spb_pkg::WORD_W-1:0] mem [0:spb_pkg::MEM_DEPTH-1];

  // ----------------------------------------------------------------
  // byte-masked write, unselected bytes untouched
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we && wmask[0]) begin
      mem[waddr][spb_pkg::BYTE_LO_LSB +: spb_pkg::BYTE_W] <=
        wdata[spb_pkg::BYTE_LO_LSB +: spb_pkg::BYTE_W];
    end
    if (we && wmask[1]) begin
      mem[waddr][spb_pkg::BYTE_HI_LSB +: spb_pkg::BYTE_W] <=
        wdata[spb_pkg::BYTE_HI_LSB +: spb_pkg::BYTE_W];
    end
  end

  assign rdata = mem[raddr];

endmodule // spb_mem_bank

// ### hw/spb_skid.sv
// two-entry buffer between burst assembly and array commit
`timescale 1ns/1ps
module spb_skid (
  input  wire logic clk,
  input  wire logic rstn,
  spb_stream_if.snk in_s,
  spb_stream_if.src out_s
);

  localparam int W = spb_pkg::CMD_W;

  logic [W-1:0] e0_reg, e0_next;
  logic [W-1:0] e1_reg, e1_next;
  logic [1:0]   cnt_reg, cnt_next;
  logic         push;
  logic         pop;

  assign in_s.ready  = (cnt_reg != 2'h2);
  assign out_s.valid = (cnt_reg != 2'h0);
  assign out_s.data  = e0_reg;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    e0_next  = e0_reg;
    e1_next  = e1_reg;
    cnt_next = cnt_reg;
    case ({push, pop})
      2'b10: begin
        if (cnt_reg == 2'h0) begin
          e0_next = in_s.data;
        end else begin
          e1_next = in_s.data;
        end
        cnt_next = cnt_reg + 2'h1;
      end
      2'b01: begin
        e0_next  = e1_reg;
        cnt_next = cnt_reg - 2'h1;
      end
      2'b11: begin
        // only reachable with one entry held, since full refuses push
        e0_next = in_s.data;
      end
      default: begin
        cnt_next = cnt_reg;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= 2'h0;
      e0_reg  <= '0;
      e1_reg  <= '0;
    end else begin
      cnt_reg <= cnt_next;
      e0_reg  <= e0_next;
      e1_reg  <= e1_next;
    end
  end

endmodule // spb_skid

// ### hw/spb_top.sv
// separate read/write port burst memory, device side
`timescale 1ns/1ps
module spb_top (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       read_port_select_n,
  input  wire logic                       write_port_select_n,
  input  wire logic [spb_pkg::ADDR_W-1:0] addr,
  input  wire logic [spb_pkg::WORD_W-1:0] wr_data,
  input  wire logic [1:0]                 byte_write_select_n,
  input  wire logic                       pll_disable_n,
  output logic      [spb_pkg::WORD_W-1:0] rd_data,
  output logic                            rd_data_oe
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [spb_pkg::PIN_W-1:0] pin_raw;
  logic [spb_pkg::PIN_W-1:0] sync1_reg;
  logic [spb_pkg::PIN_W-1:0] sync2_reg;

  assign pin_raw = {read_port_select_n, write_port_select_n, addr, wr_data,
                    byte_write_select_n, pll_disable_n};

  // selects idle high so the port comes up deselected
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_reg <= {spb_pkg::PIN_W{spb_pkg::PIN_RST_BIT}};
      sync2_reg <= {spb_pkg::PIN_W{spb_pkg::PIN_RST_BIT}};
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic                       rsel;
  logic                       wsel;
  spb_pkg::spb_addr_t         s_addr;
  spb_pkg::spb_word_t         s_data;
  logic [1:0]                 s_mask;
  logic                       legacy;

  assign rsel   = !sync2_reg[spb_pkg::PIN_W-1];
  assign wsel   = !sync2_reg[spb_pkg::PIN_W-2];
  assign s_addr = sync2_reg[spb_pkg::PIN_W-3 -: spb_pkg::ADDR_W];
  assign s_data = sync2_reg[3 +: spb_pkg::WORD_W];
  assign s_mask = ~sync2_reg[2:1];
  assign legacy = !sync2_reg[0];

  // ----------------------------------------------------------------
  // edge phase: each clk edge stands for one input clock rise
  // ----------------------------------------------------------------
  logic phase_reg, phase_next;
  logic k_edge;

  assign k_edge     = (phase_reg == spb_pkg::PHASE_K);
  assign phase_next = !phase_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_reg <= spb_pkg::PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // read start and latency pipeline
  // ----------------------------------------------------------------
  localparam int RD_D = spb_pkg::RD_DLY_DEPTH;

  logic                 rd_last_reg, rd_last_next;
  logic                 rd_go;
  logic [RD_D-1:0]      rd_v_reg, rd_v_next;
  spb_pkg::spb_addr_t   rd_a_reg [RD_D];
  spb_pkg::spb_addr_t   rd_a_next [RD_D];
  logic                 fetch;
  spb_pkg::spb_addr_t   fetch_addr;

  // a second request on the very next positive edge is dropped
  assign rd_go        = k_edge && rsel && !rd_last_reg;
  assign rd_last_next = k_edge ? rd_go : rd_last_reg;

  // array read one edge before the first word leaves
  assign fetch      = legacy ? rd_v_reg[spb_pkg::RD_LAT_LEGACY-2]
                             : rd_v_reg[spb_pkg::RD_LAT_PLL-2];
  assign fetch_addr = legacy ? rd_a_reg[spb_pkg::RD_LAT_LEGACY-2]
                             : rd_a_reg[spb_pkg::RD_LAT_PLL-2];

  always_comb begin
    rd_v_next    = {rd_v_reg[RD_D-2:0], rd_go};
    rd_a_next[0] = s_addr;
    for (int i = 1; i < RD_D; i++) begin
      rd_a_next[i] = rd_a_reg[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_last_reg <= 1'b0;
      rd_v_reg    <= '0;
      for (int i = 0; i < RD_D; i++) begin
        rd_a_reg[i] <= '0;
      end
    end else begin
      rd_last_reg <= rd_last_next;
      rd_v_reg    <= rd_v_next;
      for (int i = 0; i < RD_D; i++) begin
        rd_a_reg[i] <= rd_a_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // write start, data collection
  // ----------------------------------------------------------------
  logic                     wr_last_reg, wr_last_next;
  logic                     wr_go;
  logic [1:0]               wr_v_reg, wr_v_next;
  spb_pkg::spb_addr_t       wr_a0_reg, wr_a1_reg;
  spb_pkg::spb_wr_state_e   wst_reg, wst_next;
  logic [1:0]               wcnt_reg, wcnt_next;
  spb_pkg::spb_addr_t       col_addr_reg, col_addr_next;
  spb_pkg::spb_line_t       col_line_reg, col_line_next;
  logic [spb_pkg::MASK_W-1:0] col_mask_reg, col_mask_next;
  logic                     cmd_v_reg, cmd_v_next;
  logic                     done;

  spb_stream_if #(.W(spb_pkg::CMD_W)) cmd_if ();
  spb_stream_if #(.W(spb_pkg::CMD_W)) drain_if ();

  assign wr_go        = k_edge && wsel && !wr_last_reg;
  assign wr_last_next = k_edge ? wr_go : wr_last_reg;
  assign wr_v_next    = {wr_v_reg[0], wr_go};

  always_comb begin
    wst_next      = wst_reg;
    wcnt_next     = wcnt_reg;
    col_addr_next = col_addr_reg;
    col_line_next = col_line_reg;
    col_mask_next = col_mask_reg;
    done          = 1'b0;
    case (wst_reg)
      spb_pkg::SPB_WR_IDLE: begin
        // first word on the positive edge after the start
        if (wr_v_reg[spb_pkg::WR_DATA_DLY-1]) begin
          col_addr_next = wr_a1_reg;
          col_line_next[0 +: spb_pkg::WORD_W] = s_data;
          col_mask_next[1:0] = s_mask;
          wcnt_next = 2'h1;
          wst_next  = spb_pkg::SPB_WR_COLLECT;
        end
      end
      spb_pkg::SPB_WR_COLLECT: begin
        col_line_next[wcnt_reg*spb_pkg::WORD_W +: spb_pkg::WORD_W] = s_data;
        col_mask_next[wcnt_reg*2 +: 2] = s_mask;
        wcnt_next = wcnt_reg + 2'h1;
        if (wcnt_reg == 2'h3) begin
          done     = 1'b1;
          wst_next = spb_pkg::SPB_WR_IDLE;
        end
      end
      default: begin
        wst_next = spb_pkg::SPB_WR_IDLE;
      end
    endcase
  end

  // a finished burst waits here until the buffer takes it
  assign cmd_v_next   = done || (cmd_v_reg && !cmd_if.ready);
  assign cmd_if.valid = cmd_v_reg;
  assign cmd_if.data  = {col_addr_reg, col_mask_reg, col_line_reg};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_last_reg  <= 1'b0;
      wr_v_reg     <= '0;
      wr_a0_reg    <= '0;
      wr_a1_reg    <= '0;
      wst_reg      <= spb_pkg::SPB_WR_IDLE;
      wcnt_reg     <= '0;
      col_addr_reg <= '0;
      col_line_reg <= '0;
      col_mask_reg <= '0;
      cmd_v_reg    <= 1'b0;
    end else begin
      wr_last_reg  <= wr_last_next;
      wr_v_reg     <= wr_v_next;
      wr_a0_reg    <= s_addr;
      wr_a1_reg    <= wr_a0_reg;
      wst_reg      <= wst_next;
      wcnt_reg     <= wcnt_next;
      col_addr_reg <= col_addr_next;
      col_line_reg <= col_line_next;
      col_mask_reg <= col_mask_next;
      cmd_v_reg    <= cmd_v_next;
    end
  end

  spb_skid u_skid (
    .clk   (clk),
    .rstn  (rstn),
    .in_s  (cmd_if),
    .out_s (drain_if)
  );

  // ----------------------------------------------------------------
  // arrays: reads win the shared cycle, commits stall behind them
  // ----------------------------------------------------------------
  spb_pkg::spb_addr_t          cm_addr;
  logic [spb_pkg::MASK_W-1:0]  cm_mask;
  spb_pkg::spb_line_t          cm_line;
  spb_pkg::spb_line_t          mem_line;
  logic                        cm_we;

  assign {cm_addr, cm_mask, cm_line} = drain_if.data;
  assign drain_if.ready = !fetch;
  assign cm_we          = drain_if.valid && drain_if.ready;

  for (genvar g = 0; g < spb_pkg::BURST; g++) begin : g_bank
    spb_mem_bank u_bank (
      .clk   (clk),
      .we    (cm_we),
      .wmask (cm_mask[g*2 +: 2]),
      .waddr (cm_addr),
      .wdata (cm_line[g*spb_pkg::WORD_W +: spb_pkg::WORD_W]),
      .raddr (fetch_addr),
      .rdata (mem_line[g*spb_pkg::WORD_W +: spb_pkg::WORD_W])
    );
  end

  // ----------------------------------------------------------------
  // forwarding from the newest uncommitted burst
  // ----------------------------------------------------------------
  logic fwd_live_reg, fwd_live_next;
  logic fwd_hit;
  spb_pkg::spb_line_t fetch_line;

  function automatic spb_pkg::spb_line_t merge_bytes(
    input spb_pkg::spb_line_t          old_line,
    input spb_pkg::spb_line_t          new_line,
    input logic [spb_pkg::MASK_W-1:0]  mask
  );
    spb_pkg::spb_line_t r;
    r = old_line;
    for (int b = 0; b < spb_pkg::MASK_W; b++) begin
      if (mask[b]) begin
        r[b*spb_pkg::BYTE_W +: spb_pkg::BYTE_W] = new_line[b*spb_pkg::BYTE_W +: spb_pkg::BYTE_W];
      end
    end
    return r;
  endfunction

  // older entries still queued are not merged; the buffer drains fast enough
  assign fwd_live_next = done || ((cmd_v_reg || drain_if.valid) && fwd_live_reg);
  // collection overwrites these registers, so only a finished burst is merged
  assign fwd_hit       = fwd_live_reg && (wst_reg == spb_pkg::SPB_WR_IDLE)
                         && (col_addr_reg == fetch_addr);
  assign fetch_line    = fwd_hit ? merge_bytes(mem_line, col_line_reg, col_mask_reg)
                                 : mem_line;

  // ----------------------------------------------------------------
  // read data output
  // ----------------------------------------------------------------
  spb_pkg::spb_line_t out_line_reg, out_line_next;
  logic [2:0]         left_reg, left_next;
  spb_pkg::spb_word_t q_next;
  logic               oe_next;

  always_comb begin
    out_line_next = out_line_reg;
    left_next     = left_reg;
    q_next        = rd_data;
    oe_next       = rd_data_oe;
    if (left_reg != 3'h0) begin
      q_next        = out_line_reg[0 +: spb_pkg::WORD_W];
      out_line_next = out_line_reg >> spb_pkg::WORD_W;
      left_next     = left_reg - 3'h1;
      oe_next       = 1'b1;
    end else if (!k_edge) begin
      oe_next = 1'b0;
    end
    if (fetch) begin
      out_line_next = fetch_line;
      left_next     = 3'(spb_pkg::BURST);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fwd_live_reg <= 1'b0;
      out_line_reg <= '0;
      left_reg     <= '0;
      rd_data      <= '0;
      rd_data_oe   <= spb_pkg::OE_RST;
    end else begin
      fwd_live_reg <= fwd_live_next;
      out_line_reg <= out_line_next;
      left_reg     <= left_next;
      rd_data      <= q_next;
      rd_data_oe   <= oe_next;
    end
  end

endmodule // spb_top

// ### test/spb_props.sv
// assertion checker on the burst memory top ports
`timescale 1ns/1ps
module spb_props (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire logic                       read_port_select_n,
  input wire logic                       write_port_select_n,
  input wire logic [spb_pkg::ADDR_W-1:0] addr,
  input wire logic [spb_pkg::WORD_W-1:0] wr_data,
  input wire logic [1:0]                 byte_write_select_n,
  input wire logic                       pll_disable_n,
  input wire logic [spb_pkg::WORD_W-1:0] rd_data,
  input wire logic                       rd_data_oe
);
  // ----
  // phase: high when the coming edge is a positive clock rise
  // ----
  logic kp_reg;
  logic kp_next;
  always_comb kp_next = ~kp_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      kp_reg <= 1'b1;
    end else begin
      kp_reg <= kp_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd_req;
    $fell(read_port_select_n);
  endsequence
  // a held select must not start a second burst
  sequence s_rd_hold4;
    s_rd_req ##1 !read_port_select_n [*3] ##1 read_port_select_n;
  endsequence
  property p_reset_vals;
    $rose(rstn) |-> !rd_data_oe && rd_data == '0;
  endproperty
  property p_rd_lat_pll;
    s_rd_req ##0 pll_disable_n |-> ##8 rd_data_oe;
  endproperty
  property p_rd_lat_leg;
    s_rd_req ##0 !pll_disable_n |-> ##5 rd_data_oe;
  endproperty
  property p_burst_len;
    $rose(rd_data_oe) |-> rd_data_oe [*4];
  endproperty
  property p_rise_phase;
    $rose(rd_data_oe) |-> kp_reg == pll_disable_n;
  endproperty
  property p_drop_phase;
    $fell(rd_data_oe) |-> kp_reg;
  endproperty
  property p_rd_once;
    s_rd_hold4 ##0 pll_disable_n |-> ##4 rd_data_oe [*4] ##1 !rd_data_oe;
  endproperty
  property p_rd_idle;
    read_port_select_n [*8] |-> ##5 !rd_data_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs busy after reset");
  a_rd_lat_pll: assert property (p_rd_lat_pll) else $error("late read, pll on");
  a_rd_lat_leg: assert property (p_rd_lat_leg) else $error("late read, pll off");
  a_burst_len: assert property (p_burst_len) else $error("burst shorter than four");
  a_rise_phase: assert property (p_rise_phase) else $error("first word on wrong edge");
  a_drop_phase: assert property (p_drop_phase) else $error("release on wrong edge");
  a_rd_once: assert property (p_rd_once) else $error("second read not ignored");
  a_rd_idle: assert property (p_rd_idle) else $error("driving while deselected");
endmodule // spb_props

bind spb_top spb_props u_props (
  .clk                 (clk),
  .rstn                (rstn),
  .read_port_select_n  (read_port_select_n),
  .write_port_select_n (write_port_select_n),
  .addr                (addr),
  .wr_data             (wr_data),
  .byte_write_select_n (byte_write_select_n),
  .pll_disable_n       (pll_disable_n),
  .rd_data             (rd_data),
  .rd_data_oe          (rd_data_oe)
);

// ### test/spb_ctrl_model.sv
// memory controller model driving the port pins from a per-edge plan
`timescale 1ns/1ps
module spb_ctrl_model (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  output logic                            read_port_select_n,
  output logic                            write_port_select_n,
  output logic [spb_pkg::ADDR_W-1:0]      addr,
  output logic [spb_pkg::WORD_W-1:0]      wr_data,
  output logic [1:0]                      byte_write_select_n
);
  // plan keyed by edge number; ec counts edges since reset release
  int                 ec = -1;
  int                 k;
  bit                 rs[int];
  bit                 ws[int];
  spb_pkg::spb_addr_t ap[int];
  spb_pkg::spb_word_t dp[int];
  logic [1:0]         mp[int];
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = '0;
    wr_data = '0;
    byte_write_select_n = 2'b11;
  end
  // unplanned edges carry noise, so a deselected port sees no stale value
  always @(posedge clk) begin
    k = ec + 1;
    if (!rstn) begin
      ec <= -1;
      read_port_select_n <= 1'b1;
      write_port_select_n <= 1'b1;
    end else begin
      ec <= k;
      read_port_select_n <= !rs.exists(k);
      write_port_select_n <= !ws.exists(k);
      addr <= ap.exists(k) ? ap[k] : spb_pkg::ADDR_W'($urandom);
      wr_data <= dp.exists(k) ? dp[k] : spb_pkg::WORD_W'($urandom);
      byte_write_select_n <= mp.exists(k) ? mp[k] : 2'($urandom);
    end
  end
  task automatic rd(int e, int n, spb_pkg::spb_addr_t a);
    for (int i = 0; i < n; i++) begin
      rs[e+i] = 1'b1;
      ap[e+i] = a;
    end
  endtask
  task automatic wr(int e, int n, spb_pkg::spb_addr_t a, spb_pkg::spb_line_t d, logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      ws[e+i] = 1'b1;
      ap[e+i] = a;
    end
    for (int i = 0; i < spb_pkg::BURST; i++) begin
      dp[e+2+i] = d[spb_pkg::WORD_W*i +: spb_pkg::WORD_W];
      mp[e+2+i] = m[2*i +: 2];
    end
  endtask
endmodule // spb_ctrl_model

// ### test/tb_sep_port_burst4_sram_io.sv
// self-checking bench for the separate-port burst memory
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_sep_port_burst4_sram_io;
  logic                           clk = 1'b0;
  logic                           rstn = 1'b0;
  logic                           pll_disable_n = 1'b1;
  logic                           read_port_select_n;
  logic                           write_port_select_n;
  logic [spb_pkg::ADDR_W-1:0]     addr;
  logic [spb_pkg::WORD_W-1:0]     wr_data;
  logic [1:0]                     byte_write_select_n;
  logic [spb_pkg::WORD_W-1:0]     rd_data;
  logic                           rd_data_oe;
  wire logic [spb_pkg::WORD_W-1:0] rd_q;
  int                             bad_count = 0;
  int                             check_count = 0;
  int                             lat = spb_pkg::RD_LAT_PLL;
  spb_pkg::spb_line_t             ref_mem[int];
  spb_pkg::spb_word_t             exp_d[int];
  bit                             exp_oe[int];
  always #5 clk = ~clk;
  assign rd_q = rd_data_oe ? rd_data : 'z;
  spb_ctrl_model ctl (.clk(clk), .rstn(rstn), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr), .wr_data(wr_data),
    .byte_write_select_n(byte_write_select_n));
  spb_top dut (.clk(clk), .rstn(rstn), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .addr(addr), .wr_data(wr_data),
    .byte_write_select_n(byte_write_select_n), .pll_disable_n(pll_disable_n),
    .rd_data(rd_data), .rd_data_oe(rd_data_oe));
  // ----
  // scoreboard: every edge is judged, idle edges must float
  // ----
  always @(negedge clk) begin
    if (rstn && ctl.ec >= 0) begin
      if (exp_oe.exists(ctl.ec)) begin
        `CHK("rd_data_oe", 1'b1, rd_data_oe)
        if (exp_d.exists(ctl.ec)) `CHK("rd_data", exp_d[ctl.ec], rd_q)
      end else begin
        `CHK("rd_q idle", {spb_pkg::WORD_W{1'bz}}, rd_q)
      end
    end
  end
  function automatic spb_pkg::spb_line_t merge(spb_pkg::spb_line_t o, spb_pkg::spb_line_t n,
                                               logic [7:0] m);
    merge = o;
    for (int i = 0; i < 8; i++) if (!m[i]) merge[9*i +: 9] = n[9*i +: 9];
  endfunction
  function automatic spb_pkg::spb_addr_t adr(int i);
    return (i == 16) ? '1 : spb_pkg::ADDR_W'(i << 15);
  endfunction
  function automatic spb_pkg::spb_line_t rline();
    return spb_pkg::LINE_W'({$urandom, $urandom, $urandom});
  endfunction
  // first odd edge far enough ahead for the plan to land
  function automatic int nx();
    return (ctl.ec + 6) | 1;
  endfunction
  task automatic wr_op(int e, int n, spb_pkg::spb_addr_t a, spb_pkg::spb_line_t d, logic [7:0] m);
    ctl.wr(e, n, a, d, m);
    ref_mem[a] = merge(ref_mem.exists(a) ? ref_mem[a] : '0, d, m);
  endtask
  task automatic rd_op(int e, int n, spb_pkg::spb_addr_t a);
    int f;
    ctl.rd(e, n, a);
    f = e + 3 + lat;
    for (int i = 0; i < 4; i++) begin
      exp_d[f+i] = ref_mem[a][spb_pkg::WORD_W*i +: spb_pkg::WORD_W];
    end
    for (int i = f; i <= f + 3 + (f + 3) % 2; i++) exp_oe[i] = 1'b1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic run_to(int t, string nm);
    for (int i = 0; i < 5000 && ctl.ec < t; i++) @(posedge clk);
    if (ctl.ec < t) begin
      bad_count++;
      close_out();
    end else begin
      $display("test %s done", nm);
    end
  endtask
  initial begin
    int e;
    void'($urandom(80));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    run_to(1, "reset");
    @(negedge clk);
    `CHK("rd_data after reset", 18'h00000, rd_data)
    e = nx();
    for (int i = 0; i < 17; i++) wr_op(e + 4*i, 2, adr(i), rline(), 8'h00);
    run_to(e + 84, "fill");
    e = nx();
    for (int i = 0; i < 17; i++) rd_op(e + 4*i, 2, adr(i));
    run_to(e + 84, "readback");
    // writes and reads alternate on K edges, so each commit lands on the edge after a fetch
    e = nx();
    for (int i = 0; i < 40; i++) begin
      wr_op(e + 4*i, 2, adr($urandom_range(7)), rline(), 8'($urandom));
      rd_op(e + 4*i + 2, 2, adr(8 + $urandom_range(8)));
    end
    run_to(e + 180, "random traffic");
    e = nx();
    wr_op(e, 2, adr(3), rline(), 8'h5A);
    rd_op(e + 2, 2, adr(3));
    for (int i = 0; i < 8; i++) rd_op(e + 12 + 4*i, 2, adr(i));
    run_to(e + 60, "forwarding");
    e = nx();
    rd_op(e, 4, adr(9));
    ctl.ap[e+2] = adr(1);
    ctl.ap[e+3] = adr(1);
    wr_op(e + 16, 4, adr(2), rline(), 8'h00);
    ctl.ap[e+18] = adr(10);
    ctl.ap[e+19] = adr(10);
    rd_op(e + 40, 2, adr(10));
    rd_op(e + 44, 2, adr(2));
    run_to(e + 70, "ignored starts");
    pll_disable_n <= 1'b0;
    lat = spb_pkg::RD_LAT_LEGACY;
    e = nx() + 8;
    for (int i = 0; i < 8; i++) rd_op(e + 4*i, 2, adr(i));
    wr_op(e + 34, 2, adr(5), rline(), 8'h0F);
    rd_op(e + 50, 2, adr(5));
    run_to(e + 70, "legacy mode");
    pll_disable_n <= 1'b1;
    lat = spb_pkg::RD_LAT_PLL;
    e = nx() + 8;
    rd_op(e, 2, adr(5));
    run_to(e + 20, "pll mode again");
    close_out();
  end
endmodule // tb_sep_port_burst4_sram_io
